// ### design/pmd_consts.vh
`ifndef PMD_CONSTS_VH
`define PMD_CONSTS_VH

// Register byte offsets
`define PMD_OFS_DIS1 8'h00
`define PMD_OFS_DIS2 8'h04
`define PMD_OFS_DIS3 8'h08
`define PMD_OFS_DIS4 8'h0C
`define PMD_OFS_DIS5 8'h10
`define PMD_OFS_DIS6 8'h14

// All peripherals enabled after reset
`define PMD_RST_VAL 32'h0000_0000

// Bits that carry a peripheral in each register
`define PMD_MASK1 32'h0000_1101
`define PMD_MASK2 32'h0000_0007
`define PMD_MASK3 32'h001F_001F
`define PMD_MASK4 32'h0000_001F
`define PMD_MASK5 32'h1103_0F1F
`define PMD_MASK6 32'h0001_0003

// Register 1 fields
`define PMD_ADC_BIT      0
`define PMD_CHARGE_BIT   8
`define PMD_CMPREF_BIT   12
// Register 2 fields: comparators 1..3 from this base
`define PMD_CMP_BASE     0
// Register 3 fields: capture 1..5 and compare 1..5 from these bases
`define PMD_CAP_BASE     0
`define PMD_OCMP_BASE    16
// Register 4 fields: timers 1..5 from this base
`define PMD_TMR_BASE     0
// Register 5 fields
`define PMD_SER_BASE     0
`define PMD_SSER_BASE    8
`define PMD_TWI_BASE     16
`define PMD_USB_BIT      24
`define PMD_CAN_BIT      28
// Register 6 fields
`define PMD_CAL_BIT      0
`define PMD_REFO_BIT     1
`define PMD_PAR_BIT      16

`endif

// ### design/pmd_top.v
// Contract
// - Setting a disable bit stops all clocks to that peripheral.
// - A disabled peripheral's registers ignore writes and read invalid.
// - Cleared bit re-enables the peripheral; cleared is the reset default.
// - Register 1: ADC bit 0, charge timer bit 8, comparator reference bit 12.
// - Register 2: comparators 1, 2, 3 at bits 0, 1, 2.
// - Register 3: capture 1-5 at bits 0-4, compare 1-5 at 16-20.
// - Register 4: timers 1-5 at bits 0-4.
// - Register 5: serial, sync serial, two-wire, USB 24, CAN 28.
// - Register 6: calendar clock 0, reference clock out 1, parallel port 16.
`timescale 1ns/1ps
`include "pmd_consts.vh"

module pmd_top #(
	parameter [31:0] PRESENT1 = 32'hFFFF_FFFF,
	parameter [31:0] PRESENT2 = 32'hFFFF_FFFF,
	parameter [31:0] PRESENT3 = 32'hFFFF_FFFF,
	parameter [31:0] PRESENT4 = 32'hFFFF_FFFF,
	parameter [31:0] PRESENT5 = 32'hFFFF_FFFF,
	parameter [31:0] PRESENT6 = 32'hFFFF_FFFF
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        adc_off,
	output wire        charge_timer_off,
	output wire        cmp_ref_off,
	output wire [2:0]  comparator_off,
	output wire [4:0]  capture_off,
	output wire [4:0]  compare_off,
	output wire [4:0]  timer_off,
	output wire [4:0]  serial_off,
	output wire [3:0]  sync_serial_off,
	output wire [1:0]  twowire_off,
	output wire        usb_block_off,
	output wire        canbus_block_off,
	output wire        calendar_clock_off,
	output wire        ref_clock_out_off,
	output wire        parallel_port_off
);

	localparam [31:0] WMASK1 = `PMD_MASK1 & PRESENT1;
	localparam [31:0] WMASK2 = `PMD_MASK2 & PRESENT2;
	localparam [31:0] WMASK3 = `PMD_MASK3 & PRESENT3;
	localparam [31:0] WMASK4 = `PMD_MASK4 & PRESENT4;
	localparam [31:0] WMASK5 = `PMD_MASK5 & PRESENT5;
	localparam [31:0] WMASK6 = `PMD_MASK6 & PRESENT6;

	wire [31:0] dis1_ff;
	wire [31:0] dis2_ff;
	wire [31:0] dis3_ff;
	wire [31:0] dis4_ff;
	wire [31:0] dis5_ff;
	wire [31:0] dis6_ff;
	wire        hit1;
	wire        hit2;
	wire        hit3;
	wire        hit4;
	wire        hit5;
	wire        hit6;
	reg  [31:0] prdata_ff;
	reg         pready_ff;
	reg         pslverr_ff;
	reg  [31:0] nxt_prdata;
	reg         nxt_pslverr;
	wire        setup_phase;
	wire        wr_take;
	wire [31:0] byte_mask;

	assign setup_phase = psel & ~penable;
	// Writes land only at the access edge, so a held request cannot write twice
	assign wr_take = psel & penable & pready_ff & pwrite;
	// A lane whose strobe is low keeps its old bits
	assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Answer is prepared in the setup cycle so the access phase never waits
	always @* begin
		nxt_prdata = 32'h0000_0000;
		// Unmapped offsets answer with an error and read as zero
		nxt_pslverr = ~(hit1 | hit2 | hit3 | hit4 | hit5 | hit6);
		if (hit1) begin
			nxt_prdata = dis1_ff;
		end
		if (hit2) begin
			nxt_prdata = dis2_ff;
		end
		if (hit3) begin
			nxt_prdata = dis3_ff;
		end
		if (hit4) begin
			nxt_prdata = dis4_ff;
		end
		if (hit5) begin
			nxt_prdata = dis5_ff;
		end
		if (hit6) begin
			nxt_prdata = dis6_ff;
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup_phase;
			pslverr_ff <= setup_phase & nxt_pslverr;
			if (setup_phase && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Each register decodes its own offset; the read mux and the error
	// response are built from the six hits.
	// Disable register 1
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS1),
		.IMPL  (WMASK1),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_1_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit1),
		.value     (dis1_ff)
	);

	// Disable register 2
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS2),
		.IMPL  (WMASK2),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_2_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit2),
		.value     (dis2_ff)
	);

	// Disable register 3
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS3),
		.IMPL  (WMASK3),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_3_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit3),
		.value     (dis3_ff)
	);

	// Disable register 4
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS4),
		.IMPL  (WMASK4),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_4_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit4),
		.value     (dis4_ff)
	);

	// Disable register 5
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS5),
		.IMPL  (WMASK5),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_5_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit5),
		.value     (dis5_ff)
	);

	// Disable register 6
	pmd_dis_reg #(
		.ADDR  (`PMD_OFS_DIS6),
		.IMPL  (WMASK6),
		.RESET (`PMD_RST_VAL)
	) pmd_dis_reg_6_i (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_take   (wr_take),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.byte_mask (byte_mask),
		.hit       (hit6),
		.value     (dis6_ff)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Each off flag is both the clock-stop enable and the register-access
	// block of its peripheral; the peripheral must gate both on it.
	// Bare flop outputs, so no decode glitch can reach a clock gate
	// clock stop flags
	assign adc_off = dis1_ff[`PMD_ADC_BIT];
	assign charge_timer_off = dis1_ff[`PMD_CHARGE_BIT];
	assign cmp_ref_off = dis1_ff[`PMD_CMPREF_BIT];
	assign comparator_off = dis2_ff[`PMD_CMP_BASE +: 3];
	assign capture_off = dis3_ff[`PMD_CAP_BASE +: 5];
	assign compare_off = dis3_ff[`PMD_OCMP_BASE +: 5];
	assign timer_off = dis4_ff[`PMD_TMR_BASE +: 5];
	assign serial_off = dis5_ff[`PMD_SER_BASE +: 5];
	assign sync_serial_off = dis5_ff[`PMD_SSER_BASE +: 4];
	assign twowire_off = dis5_ff[`PMD_TWI_BASE +: 2];
	// USB busy state is not seen here; software must wait for idle first
	assign usb_block_off = dis5_ff[`PMD_USB_BIT];
	assign canbus_block_off = dis5_ff[`PMD_CAN_BIT];
	assign calendar_clock_off = dis6_ff[`PMD_CAL_BIT];
	assign ref_clock_out_off = dis6_ff[`PMD_REFO_BIT];
	assign parallel_port_off = dis6_ff[`PMD_PAR_BIT];

endmodule // pmd_top

// One disable register. Only bits set in IMPL can ever change, so a bit
// with no peripheral behind it keeps its reset value and reads zero.
module pmd_dis_reg #(
	parameter [7:0]  ADDR  = 8'h00,
	parameter [31:0] IMPL  = 32'h0000_0000,
	parameter [31:0] RESET = 32'h0000_0000
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        wr_take,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [31:0] byte_mask,
	output wire        hit,
	output wire [31:0] value
);

	reg  [31:0] value_ff;
	wire        wr_en;
	wire [31:0] wmask;
	wire [31:0] nxt_value;

	// Offset decode for this register only
	assign hit = (paddr == ADDR);
	// Needs both the access edge and a matching offset
	assign wr_en = wr_take & hit;

	assign wmask = byte_mask & IMPL;
	assign nxt_value = (value_ff & ~wmask) | (pwdata & wmask);

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			value_ff <= RESET;
		end else if (wr_en) begin
			value_ff <= nxt_value;
		end
	end

	assign value = value_ff;

endmodule // pmd_dis_reg

// ### verification/pmd_props.sv
`timescale 1ns/1ps
module pmd_props (
	input wire        mclk,
	input wire        nrst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        adc_off,
	input wire [4:0]  timer_off,
	input wire        usb_block_off
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire wr = psel && penable && pready && pwrite && !pslverr;
	a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single pulse");
	a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
		else $error("unmapped address accepted");
	a_off_hold: assert property (!wr |=> $stable({adc_off, timer_off, usb_block_off}))
		else $error("disable output moved without write");
	a_adc_bit: assert property (wr && paddr == 8'h00 && pstrb[0] |=> adc_off == $past(pwdata[0]))
		else $error("adc disable wrong");
	a_timer_bits: assert property (wr && paddr == 8'h0C && pstrb[0] |=> timer_off == $past(pwdata[4:0]))
		else $error("timer disables wrong");
	a_usb_bit: assert property (wr && paddr == 8'h10 && pstrb[3] |=> usb_block_off == $past(pwdata[24]))
		else $error("usb disable wrong");
	a_reset_clear: assert property ($rose(nrst) |-> !adc_off && timer_off == 5'h00)
		else $error("disables set after reset");
	cover property (wr);
	cover property (pslverr);
	cover property (pready && !pwrite);
endmodule // pmd_props

// ### verification/peripheral_module_disable_tb.sv
`timescale 1ns/1ps
module peripheral_module_disable_tb;
	reg         mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0000_0000, rd;
	reg  [3:0]  pstrb = 4'h0;
	wire [31:0] prdata;
	wire        pready, pslverr, adc_off, charge_timer_off, cmp_ref_off, usb_block_off;
	wire        canbus_block_off, calendar_clock_off, ref_clock_out_off, parallel_port_off;
	wire [2:0]  comparator_off;
	wire [4:0]  capture_off, compare_off, timer_off, serial_off;
	wire [3:0]  sync_serial_off;
	wire [1:0]  twowire_off;
	wire [36:0] offs = {adc_off, charge_timer_off, cmp_ref_off, comparator_off, capture_off,
		compare_off, timer_off, serial_off, sync_serial_off, twowire_off, usb_block_off,
		canbus_block_off, calendar_clock_off, ref_clock_out_off, parallel_port_off};
	reg  [31:0] mask [6] = '{32'h0000_1101, 32'h0000_0007, 32'h001F_001F, 32'h0000_001F,
		32'h1103_0F1F, 32'h0001_0003};
	integer     miscompares = 0, total_checks = 0, cyc = 0, i;
	pmd_top pmd_top_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_off(adc_off),
		.charge_timer_off(charge_timer_off), .cmp_ref_off(cmp_ref_off),
		.comparator_off(comparator_off), .capture_off(capture_off),
		.compare_off(compare_off), .timer_off(timer_off), .serial_off(serial_off),
		.sync_serial_off(sync_serial_off), .twowire_off(twowire_off),
		.usb_block_off(usb_block_off), .canbus_block_off(canbus_block_off),
		.calendar_clock_off(calendar_clock_off), .ref_clock_out_off(ref_clock_out_off),
		.parallel_port_off(parallel_port_off));
	always #5 mclk = ~mclk;
	task check(input [36:0] got, input [36:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen at an edge
	task xfer(input w, input [7:0] a, input [31:0] d, input [3:0] s);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task t_reset;
		for (i = 0; i < 6; i++) begin
			xfer(0, 4 * i, 0, 0);
			check(rd, 0);
		end
		check(offs, 0);
		$display("reset test done");
	endtask
	task t_fill;
		for (i = 0; i < 6; i++) xfer(1, 4 * i, 32'hFFFF_FFFF, 4'hF);
		@(posedge mclk);
		check(offs, {37{1'b1}});
		for (i = 0; i < 6; i++) begin
			xfer(0, 4 * i, 0, 0);
			check(rd, mask[i]);
		end
		$display("fill test done");
	endtask
	task t_strobe;
		xfer(1, 8'h0C, 32'h0000_0000, 4'h1);
		xfer(1, 8'h10, 32'h0000_0000, 4'h7);
		xfer(0, 8'h10, 0, 0);
		check(rd, 32'h1100_0000);
		check(timer_off, 0);
		check(usb_block_off, 1);
		$display("strobe test done");
	endtask
	task t_unmapped;
		xfer(1, 8'h18, 32'hFFFF_FFFF, 4'hF);
		check(err, 1);
		xfer(0, 8'h18, 0, 0);
		check({err, rd}, 33'h1_0000_0000);
		xfer(0, 8'h00, 0, 0);
		check(rd, 32'h0000_1101);
		$display("unmapped test done");
	endtask
	task t_layout;
		xfer(1, 8'h00, 32'h0000_1001, 4'hF);
		xfer(1, 8'h04, 32'h0000_0005, 4'hF);
		xfer(1, 8'h08, 32'h0005_000A, 4'hF);
		xfer(1, 8'h0C, 32'h0000_000C, 4'hF);
		xfer(1, 8'h10, 32'h1002_0A15, 4'hF);
		xfer(1, 8'h14, 32'h0001_0001, 4'hF);
		@(posedge mclk);
		check({adc_off, charge_timer_off, cmp_ref_off}, 3'h5);
		check(comparator_off, 3'h5);
		check(capture_off, 5'h0A);
		check(compare_off, 5'h05);
		check(timer_off, 5'h0C);
		check(serial_off, 5'h15);
		check(sync_serial_off, 4'hA);
		check(twowire_off, 2'h2);
		check({usb_block_off, canbus_block_off}, 2'h1);
		check({calendar_clock_off, ref_clock_out_off, parallel_port_off}, 3'h5);
		$display("layout test done");
	endtask
	task t_midreset;
		@(posedge mclk);
		nrst <= 1'b0;
		@(posedge mclk);
		check(offs, 0);
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		xfer(0, 8'h00, 0, 0);
		check(rd, 0);
		xfer(0, 8'h10, 0, 0);
		check(rd, 0);
		$display("mid-run reset test done");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc > 2000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		t_reset;
		t_fill;
		t_strobe;
		t_unmapped;
		t_layout;
		t_midreset;
		conclude;
	end
endmodule // peripheral_module_disable_tb
bind pmd_top pmd_props pmd_props_i (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .adc_off, .timer_off, .usb_block_off);
